/* logic/rfp_pkg.sv */
package rfp_pkg;
    localparam logic [5:0] ADDR_PA_TABLE = 6'h3E;
    localparam logic [5:0] ADDR_FIFO = 6'h3F;
    localparam logic [7:0] HDR_TX_SINGLE = 8'h3F;
    localparam logic [7:0] HDR_TX_BURST = 8'h7F;
    localparam logic [7:0] HDR_RX_SINGLE = 8'hBF;
    localparam logic [7:0] HDR_RX_BURST = 8'hFF;
    localparam logic [5:0] ADDR_STROBE_LO = 6'h30;
    localparam logic [5:0] ADDR_STROBE_HI = 6'h3D;
    localparam logic [5:0] ADDR_STB_RX = 6'h34;
    localparam logic [5:0] ADDR_STB_TX = 6'h35;
    localparam logic [5:0] ADDR_STB_IDLE = 6'h36;
    localparam logic [5:0] ADDR_STB_PWD = 6'h39;
    localparam logic [5:0] ADDR_STB_FRX = 6'h3A;
    localparam logic [5:0] ADDR_STB_FTX = 6'h3B;
    localparam int FIFO_DEPTH = 64;
    localparam int FIFO_CW = 7;
    localparam logic [6:0] FIFO_FULL_COUNT = 7'h40;
    localparam int PA_ENTRIES = 8;
    localparam logic [2:0] PA_IDX_FIRST = 3'h0;
    localparam logic [2:0] PA_IDX_LAST = 3'h7;
    localparam logic [7:0] PA_RESET = 8'h00;
    localparam logic [3:0] AVAIL_MAX = 4'hF;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [2:0] ST_CODE_IDLE = 3'h0;
    localparam logic [2:0] ST_CODE_RX = 3'h1;
    localparam logic [2:0] ST_CODE_TX = 3'h2;
    localparam logic [2:0] ST_CODE_RX_OVF = 3'h6;
    localparam logic [2:0] ST_CODE_TX_UNF = 3'h7;
    localparam logic CHIP_READY_N = 1'b0;
    localparam logic [8:0] RATE_BASE = 9'h100;
    localparam int RATE_ACC_W = 29;
    localparam int RATE_FRAC_MSB = 28;
    localparam logic [1:0] PIN_CMD_PWD = 2'h0;
    localparam logic [1:0] PIN_CMD_TX = 2'h1;
    localparam logic [1:0] PIN_CMD_IDLE = 2'h2;
    localparam logic [1:0] PIN_CMD_RX = 2'h3;

    typedef struct packed {
        logic rw;
        logic burst;
        logic [5:0] addr;
    } rfp_hdr_s;

    typedef struct packed {
        logic rdy_n;
        logic [2:0] state;
        logic [3:0] avail;
    } rfp_status_s;

    typedef enum logic [2:0] {RS_SLEEP, RS_IDLE, RS_RX, RS_TX, RS_RX_OVF, RS_TX_UNF} rfp_radio_e;
endpackage : rfp_pkg

/* logic/rfp_radio_port.sv */
`timescale 1ns/10ps
module rfp_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 8,
    parameter int CW = $clog2(DEPTH) + 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic flush,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data,
    output logic [CW-1:0] count
);
    localparam int AW = CW - 1;
    logic [W-1:0] mem_r [DEPTH];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [CW-1:0] cnt_r;
    wire push = in_valid & in_ready;
    wire pop = out_valid & out_ready;
    assign in_ready = (cnt_r != CW'(DEPTH));
    assign out_valid = (cnt_r != '0);
    assign out_data = mem_r[rp_r];
    assign count = cnt_r;

    always_ff @(posedge clk)
    begin
        if (!rst_n || flush)
        begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end
        else
        begin
            if (push)
            begin
                mem_r[wp_r] <= in_data;
                wp_r <= AW'(wp_r + 1'b1);
            end
            if (pop)
                rp_r <= AW'(rp_r + 1'b1);
            cnt_r <= CW'(cnt_r + CW'(push) - CW'(pop));
        end
    end
endmodule : rfp_fifo

module rfp_radio_port (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic chip_select_n,
    input wire logic sclk,
    input wire logic si,
    output logic shared_status_output_o,
    output logic shared_status_output_oe_n,
    input wire logic status_pin_general_en,
    input wire logic status_pin_general_value,
    input wire logic general_output_a_i,
    output logic general_output_a_o,
    output logic general_output_a_oe_n,
    input wire logic general_output_a_value,
    input wire logic serial_mode_en,
    output logic serial_tx_bit,
    input wire logic pin_control_enable,
    input wire logic [2:0] pa_power_index,
    output logic [7:0] pa_power_setting,
    input wire logic [7:0] rate_mantissa,
    input wire logic [3:0] rate_exponent,
    output logic symbol_tick,
    output logic tx_byte_valid,
    input wire logic tx_byte_ready,
    output logic [7:0] tx_byte_data,
    input wire logic rx_byte_valid,
    output logic rx_byte_ready,
    input wire logic [7:0] rx_byte_data,
    output rfp_pkg::rfp_status_s radio_status
);
    import rfp_pkg::*;

    function automatic logic [3:0] sat_avail(input logic [FIFO_CW-1:0] n);
        sat_avail = (n > FIFO_CW'(AVAIL_MAX)) ? AVAIL_MAX : n[3:0];
    endfunction : sat_avail

    logic cs_m_r, cs_s_r, cs_d_r, sck_m_r, sck_s_r, sck_d_r, si_m_r, si_s_r, ga_m_r, ga_s_r;
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            {cs_m_r, cs_s_r, cs_d_r} <= 3'h7;
            {sck_m_r, sck_s_r, sck_d_r, si_m_r, si_s_r, ga_m_r, ga_s_r} <= 7'h00;
        end
        else
        begin
            {cs_m_r, cs_s_r, cs_d_r} <= {chip_select_n, cs_m_r, cs_s_r};
            {sck_m_r, sck_s_r, sck_d_r} <= {sclk, sck_m_r, sck_s_r};
            {si_m_r, si_s_r} <= {si, si_m_r};
            {ga_m_r, ga_s_r} <= {general_output_a_i, ga_m_r};
        end
    end

    wire cs_low = ~cs_s_r;
    wire cs_fall = cs_d_r & ~cs_s_r;
    wire cs_rise = ~cs_d_r & cs_s_r;
    // clock edges count only while selected
    wire sck_rise = cs_low & ~cs_d_r & sck_s_r & ~sck_d_r;
    wire sck_fall = cs_low & ~cs_d_r & ~sck_s_r & sck_d_r;

    rfp_radio_e st_r, st_nxt;
    logic [2:0] bit_cnt_r;
    logic [7:0] shin_r;
    logic [7:0] so_r;
    logic in_data_r;
    rfp_hdr_s hdr_r;
    logic [2:0] pa_idx_r;
    logic pwd_pend_r;
    logic [7:0] pa_r [PA_ENTRIES];
    logic [RATE_ACC_W-1:0] acc_r;
    logic [7:0] pa_out_r;
    logic tick_r, ser_bit_r;
    logic rx_reload_r;

    wire [7:0] rx_byte = {shin_r[6:0], si_s_r};
    wire byte_done = sck_rise & (bit_cnt_r == BIT_LAST);
    rfp_hdr_s hdr_now;
    assign hdr_now = rfp_hdr_s'(rx_byte);
    wire hdr_done = byte_done & ~in_data_r;
    wire dat_done = byte_done & in_data_r;
    wire is_strobe = ~hdr_now.burst & (hdr_now.addr >= ADDR_STROBE_LO) & (hdr_now.addr <= ADDR_STROBE_HI);
    wire stb_hit = hdr_done & is_strobe;
    // next byte is data after a non-strobe header, or inside a burst
    wire next_data = hdr_done ? ~is_strobe : (dat_done & hdr_r.burst);
    rfp_hdr_s hdr_use;
    assign hdr_use = hdr_done ? hdr_now : hdr_r;
    wire rd_fifo_next = next_data & hdr_use.rw & (hdr_use.addr == ADDR_FIFO);
    wire rd_pa_next = next_data & hdr_use.rw & (hdr_use.addr == ADDR_PA_TABLE);
    wire wr_fifo = dat_done & ~hdr_r.rw & (hdr_r.addr == ADDR_FIFO);
    wire wr_pa = dat_done & ~hdr_r.rw & (hdr_r.addr == ADDR_PA_TABLE);

    wire tx_in_ready, tx_out_valid, rx_in_ready, rx_out_valid;
    wire [7:0] rx_head;
    wire [FIFO_CW-1:0] tx_cnt, rx_cnt;
    wire st_flush_ok = (st_r == RS_IDLE) | (st_r == RS_TX_UNF) | (st_r == RS_RX_OVF);
    wire flush_tx_strobe = stb_hit & (hdr_now.addr == ADDR_STB_FTX) & st_flush_ok;
    wire flush_rx_strobe = stb_hit & (hdr_now.addr == ADDR_STB_FRX) & st_flush_ok;
    wire enter_sleep = pwd_pend_r & cs_rise & (st_r != RS_SLEEP);
    wire tx_flush = flush_tx_strobe | enter_sleep;
    wire rx_flush = flush_rx_strobe | enter_sleep;
    // pop only once the byte has fully left on the serial output
    wire rd_fifo_done = dat_done & hdr_r.rw & (hdr_r.addr == ADDR_FIFO);
    wire rx_pop = rd_fifo_done & rx_out_valid;

    rfp_fifo #(.W(8), .DEPTH(FIFO_DEPTH), .CW(FIFO_CW)) u_tx_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .flush(tx_flush),
        .in_valid(wr_fifo),
        .in_ready(tx_in_ready),
        .in_data(rx_byte),
        .out_valid(tx_out_valid),
        .out_ready(tx_byte_ready & (st_r == RS_TX)),
        .out_data(tx_byte_data),
        .count(tx_cnt)
    );

    rfp_fifo #(.W(8), .DEPTH(FIFO_DEPTH), .CW(FIFO_CW)) u_rx_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .flush(rx_flush),
        .in_valid(rx_byte_valid & (st_r == RS_RX)),
        .in_ready(rx_in_ready),
        .in_data(rx_byte_data),
        .out_valid(rx_out_valid),
        .out_ready(rx_pop),
        .out_data(rx_head),
        .count(rx_cnt)
    );

    assign tx_byte_valid = tx_out_valid & (st_r == RS_TX);
    assign rx_byte_ready = rx_in_ready & (st_r == RS_RX);

    logic [2:0] st_code;
    always_comb
    begin
        case (st_r)
            RS_RX: st_code = ST_CODE_RX;
            RS_TX: st_code = ST_CODE_TX;
            RS_RX_OVF: st_code = ST_CODE_RX_OVF;
            RS_TX_UNF: st_code = ST_CODE_TX_UNF;
            default: st_code = ST_CODE_IDLE;
        endcase
    end

    // byte finishing on this clock already counts as stored
    wire tx_push = wr_fifo & tx_in_ready;
    wire [FIFO_CW-1:0] tx_free = FIFO_CW'(FIFO_FULL_COUNT - tx_cnt - FIFO_CW'(tx_push));
    rfp_status_s stat_wr, stat_rd;
    assign stat_wr = '{rdy_n: CHIP_READY_N, state: st_code, avail: sat_avail(tx_free)};
    assign stat_rd = '{rdy_n: CHIP_READY_N, state: st_code, avail: sat_avail(rx_cnt)};
    assign radio_status = stat_rd;
    wire [7:0] so_load = rd_fifo_next ? rx_head :
                         rd_pa_next ? pa_r[pa_idx_r] :
                         (next_data & hdr_use.rw) ? 8'h00 :
                         hdr_use.rw ? stat_rd : stat_wr;

    // pin control strobes on chip select fall
    wire [1:0] pin_cmd = {sck_s_r, si_s_r};
    wire pin_go = pin_control_enable & cs_fall & (st_r != RS_SLEEP);
    wire do_idle = (stb_hit & (hdr_now.addr == ADDR_STB_IDLE)) | (pin_go & (pin_cmd == PIN_CMD_IDLE));
    wire do_rx = (stb_hit & (hdr_now.addr == ADDR_STB_RX)) | (pin_go & (pin_cmd == PIN_CMD_RX));
    wire do_tx = (stb_hit & (hdr_now.addr == ADDR_STB_TX)) | (pin_go & (pin_cmd == PIN_CMD_TX));
    wire do_pwd = (stb_hit & (hdr_now.addr == ADDR_STB_PWD)) | (pin_go & (pin_cmd == PIN_CMD_PWD));

    always_comb
    begin
        st_nxt = st_r;
        case (st_r)
            RS_SLEEP:
                if (cs_fall)
                    st_nxt = RS_IDLE;
            RS_IDLE:
                if (do_tx)
                    st_nxt = RS_TX;
                else if (do_rx)
                    st_nxt = RS_RX;
            RS_RX:
                if (do_idle)
                    st_nxt = RS_IDLE;
                else if (do_tx)
                    st_nxt = RS_TX;
                else if (rx_byte_valid & ~rx_in_ready)
                    st_nxt = RS_RX_OVF;
            RS_TX:
                if (do_idle)
                    st_nxt = RS_IDLE;
                else if (tx_byte_ready & ~tx_out_valid)
                    st_nxt = RS_TX_UNF;
            RS_RX_OVF:
                if (do_idle | flush_rx_strobe)
                    st_nxt = RS_IDLE;
            RS_TX_UNF:
                if (do_idle | flush_tx_strobe)
                    st_nxt = RS_IDLE;
            default:
                st_nxt = RS_IDLE;
        endcase
        if (enter_sleep)
            st_nxt = RS_SLEEP;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            st_r <= RS_IDLE;
        else
            st_r <= st_nxt;
    end

    // serial shifter; SO changes on falling clock, not after the last bit
    always_ff @(posedge clk)
    begin
        if (!rst_n || cs_s_r)
        begin
            bit_cnt_r <= 3'h0;
            shin_r <= 8'h00;
            in_data_r <= 1'b0;
        end
        else if (sck_rise)
        begin
            bit_cnt_r <= 3'(bit_cnt_r + 1'b1);
            shin_r <= rx_byte;
            if (byte_done)
                in_data_r <= next_data;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            so_r <= 8'h00;
            hdr_r <= '0;
            rx_reload_r <= 1'b0;
        end
        else
        begin
            if (cs_fall)
                so_r <= hdr_r.rw ? stat_rd : stat_wr;
            else if (byte_done)
                so_r <= so_load;
            // head moves one clock after the pop; take the new one
            else if (rx_reload_r)
                so_r <= rx_head;
            else if (sck_fall && bit_cnt_r != 3'h0)
                so_r <= {so_r[6:0], 1'b0};
            if (hdr_done)
                hdr_r <= hdr_now;
            rx_reload_r <= rd_fifo_done & rd_fifo_next;
        end
    end

    // power table and its index
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            pa_idx_r <= PA_IDX_FIRST;
            pwd_pend_r <= 1'b0;
            for (int i = 0; i < PA_ENTRIES; i++)
                pa_r[i] <= PA_RESET;
        end
        else
        begin
            if (cs_s_r)
                pa_idx_r <= PA_IDX_FIRST;
            else if (wr_pa || rd_pa_next)
                pa_idx_r <= (pa_idx_r == PA_IDX_LAST) ? PA_IDX_FIRST : 3'(pa_idx_r + 1'b1);
            if (enter_sleep)
            begin
                for (int i = 1; i < PA_ENTRIES; i++)
                    pa_r[i] <= PA_RESET;
            end
            else if (wr_pa)
                pa_r[pa_idx_r] <= rx_byte;
            if (do_pwd)
                pwd_pend_r <= 1'b1;
            else if (cs_rise)
                pwd_pend_r <= 1'b0;
        end
    end

    // symbol rate accumulator; mantissa is 8 bits so 256+m fits 9 bits
    wire [RATE_ACC_W-1:0] rate_inc = RATE_ACC_W'(RATE_BASE + {1'b0, rate_mantissa}) << rate_exponent;
    wire [RATE_ACC_W-1:0] acc_sum = {1'b0, acc_r[RATE_FRAC_MSB-1:0]} + rate_inc;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            acc_r <= '0;
            tick_r <= 1'b0;
            pa_out_r <= PA_RESET;
            ser_bit_r <= 1'b0;
        end
        else
        begin
            acc_r <= acc_sum;
            tick_r <= acc_sum[RATE_FRAC_MSB];
            pa_out_r <= pa_r[pa_power_index];
            ser_bit_r <= ga_s_r;
        end
    end

    wire ga_is_input = serial_mode_en & (st_r == RS_TX);
    assign symbol_tick = tick_r;
    assign pa_power_setting = pa_out_r;
    assign serial_tx_bit = ga_is_input ? ser_bit_r : 1'b0;
    assign general_output_a_o = general_output_a_value;
    assign general_output_a_oe_n = ga_is_input;
    assign shared_status_output_o = cs_low ? so_r[7] : status_pin_general_value;
    assign shared_status_output_oe_n = ~(cs_low | status_pin_general_en);

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_deselect;
        cs_s_r;
    endsequence
    sequence s_single_byte;
        dat_done && !hdr_r.burst;
    endsequence

    property p_idx_clear;
        s_deselect |=> pa_idx_r == PA_IDX_FIRST;
    endproperty
    a_idx_clear: assert property (p_idx_clear) else $error("table index not cleared");
    property p_idx_wrap;
        (wr_pa && pa_idx_r == PA_IDX_LAST && !cs_s_r) |=> pa_idx_r == PA_IDX_FIRST;
    endproperty
    a_idx_wrap: assert property (p_idx_wrap) else $error("table index did not wrap");
    property p_sleep_empties;
        enter_sleep |=> (tx_cnt == '0) && (rx_cnt == '0) && st_r == RS_SLEEP;
    endproperty
    a_sleep_empties: assert property (p_sleep_empties) else $error("fifos not empty in sleep");
    property p_sleep_keeps0;
        enter_sleep |=> pa_r[0] == $past(pa_r[0]) && pa_r[PA_ENTRIES-1] == PA_RESET;
    endproperty
    a_sleep_keeps0: assert property (p_sleep_keeps0) else $error("table sleep handling wrong");
    property p_flush_gate;
        (flush_tx_strobe || flush_rx_strobe) |-> $past(st_nxt) != RS_TX && st_r != RS_TX && st_r != RS_RX;
    endproperty
    a_flush_gate: assert property (p_flush_gate) else $error("flush in wrong state");
    property p_so_drive;
        !cs_s_r |-> !shared_status_output_oe_n ##1 (cs_s_r || !shared_status_output_oe_n);
    endproperty
    a_so_drive: assert property (p_so_drive) else $error("serial out not driven");
    property p_single_ends;
        s_single_byte ##1 !cs_s_r |-> !in_data_r;
    endproperty
    a_single_ends: assert property (p_single_ends) else $error("single access kept data phase");
    property p_pwd_waits;
        (pwd_pend_r && !cs_s_r) |=> st_r != RS_SLEEP || $past(st_r) == RS_SLEEP;
    endproperty
    a_pwd_waits: assert property (p_pwd_waits) else $error("power down before deselect");
    property p_wake;
        (st_r == RS_SLEEP && cs_fall) |=> st_r == RS_IDLE;
    endproperty
    a_wake: assert property (p_wake) else $error("select did not wake");
    property p_pin_rx;
        (pin_go && pin_cmd == PIN_CMD_RX && st_r == RS_IDLE && !stb_hit) |=> st_r == RS_RX;
    endproperty
    a_pin_rx: assert property (p_pin_rx) else $error("pin receive strobe lost");
    property p_tx_status;
        (byte_done && next_data && !hdr_use.rw && hdr_use.addr == ADDR_FIFO && st_r != RS_TX)
            |=> so_r[3:0] == sat_avail(FIFO_CW'(FIFO_FULL_COUNT - tx_cnt));
    endproperty
    a_tx_status: assert property (p_tx_status) else $error("transmit status count wrong");
endmodule : rfp_radio_port

/* test/rfp_host_model.sv */
`timescale 1ns/10ps
module rfp_host_model (
    input wire logic clk,
    input wire logic so,
    output logic chip_select_n,
    output logic sclk,
    output logic si,
    output logic [7:0] got,
    output logic got_v
);
    initial
    begin
        chip_select_n = 1'b1;
        sclk = 1'b0;
        si = 1'b0;
        got = 8'h00;
        got_v = 1'b0;
    end
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask : wt
    task automatic sel;
        chip_select_n <= 1'b0;
        wt(8);
    endtask : sel
    // header or data byte, mode 0, msb first, half period 4 clocks
    task automatic xfer(input logic [7:0] d, input bit watch);
        for (int i = 7; i >= 0; i--)
        begin
            si <= d[i];
            wt(4);
            sclk <= 1'b1;
            got <= {got[6:0], so};
            wt(4);
            sclk <= 1'b0;
        end
        got_v <= watch;
        wt(1);
        got_v <= 1'b0;
        wt(3);
    endtask : xfer
    // ends a burst and rewinds the table index
    task automatic desel;
        wt(4);
        chip_select_n <= 1'b1;
        si <= ~si;
        wt(8);
    endtask : desel
    task automatic pin(input logic [1:0] c);
        sclk <= c[1];
        si <= c[0];
        wt(8);
        chip_select_n <= 1'b0;
        wt(8);
        chip_select_n <= 1'b1;
        wt(8);
        sclk <= 1'b0;
        si <= 1'b0;
        wt(8);
    endtask : pin
    task automatic wiggle;
        repeat (6)
        begin
            sclk <= ~sclk;
            si <= ~si;
            wt(2);
        end
    endtask : wiggle
endmodule : rfp_host_model

/* test/tb_rfp_radio_port.sv */
`timescale 1ns/10ps
module tb_rfp_radio_port;
    import rfp_pkg::*;
    logic clk, rst_n, chip_select_n, sclk, si, shared_status_output_o, shared_status_output_oe_n;
    logic status_pin_general_en, status_pin_general_value, general_output_a_i, general_output_a_value;
    logic serial_mode_en, pin_control_enable, tx_byte_valid, tx_byte_ready, rx_byte_valid, rx_byte_ready;
    logic [2:0] pa_power_index;
    logic [7:0] pa_power_setting, rate_mantissa, tx_byte_data, rx_byte_data, got;
    logic [3:0] rate_exponent;
    logic got_v;
    logic general_output_a_o, general_output_a_oe_n, serial_tx_bit, symbol_tick, tick_on;
    rfp_status_s radio_status;
    int fail_count = 0;
    int checks = 0;
    int cyc = 0;
    int ticks = 0;
    logic [15:0] seed = 16'h232A;
    logic [7:0] exp_so[$];
    logic [7:0] exp_tx[$];
    logic [7:0] pa[8];

    rfp_radio_port dut (.clk, .rst_n, .chip_select_n, .sclk, .si, .shared_status_output_o,
        .shared_status_output_oe_n, .status_pin_general_en, .status_pin_general_value, .general_output_a_i,
        .general_output_a_o, .general_output_a_oe_n, .general_output_a_value, .serial_mode_en,
        .serial_tx_bit, .pin_control_enable, .pa_power_index, .pa_power_setting, .rate_mantissa,
        .rate_exponent, .symbol_tick, .tx_byte_valid, .tx_byte_ready, .tx_byte_data, .rx_byte_valid,
        .rx_byte_ready, .rx_byte_data, .radio_status);
    rfp_host_model m (.clk, .so(shared_status_output_o), .chip_select_n, .sclk, .si, .got, .got_v);

    function automatic logic [15:0] nxt(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : nxt
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : print_verdict
    task automatic stb(input logic [5:0] a);
        m.sel();
        m.xfer({2'b00, a}, 0);
        m.desel();
    endtask : stb
    task automatic rx_in(input logic [7:0] d);
        rx_byte_valid <= 1'b1;
        rx_byte_data <= d;
        do @(negedge clk); while (rx_byte_ready !== 1'b1);
        @(posedge clk);
    endtask : rx_in

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc > 30000)
        begin
            fail_count++;
            print_verdict();
        end
        if (got_v)
            chk(got, exp_so.pop_front());
        if (tx_byte_valid && tx_byte_ready)
            chk(tx_byte_data, exp_tx.pop_front());
        if (tick_on && symbol_tick)
            ticks <= ticks + 1;
    end

    initial
    begin
        rst_n = 1'b0;
        {status_pin_general_en, status_pin_general_value, general_output_a_i} = seed[2:0];
        {general_output_a_value, serial_mode_en, pin_control_enable, pa_power_index} = 6'h00;
        tick_on = 1'b0;
        rate_mantissa = seed[15:8]; // 8-bit field, 256 is never programmed
        rate_exponent = seed[7:4];
        {tx_byte_ready, rx_byte_valid, rx_byte_data} = 10'h000;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        chk({7'h00, shared_status_output_oe_n}, {7'h00, ~status_pin_general_en});
        m.sel();
        m.xfer(HDR_TX_BURST, 0);
        for (int i = 0; i < 65; i++)
        begin
            seed = nxt(seed);
            if (i < 64)
                exp_tx.push_back(seed[7:0]);
            exp_so.push_back(i > 49 ? 8'(64 - i) : 8'h0F);
            m.xfer(seed[7:0], 1);
        end
        m.desel();
        tx_byte_ready <= 1'b1;
        stb(ADDR_STB_TX);
        m.wt(80);
        chk(8'(exp_tx.size()), 8'h00);
        chk({5'h00, radio_status.state}, {5'h00, ST_CODE_TX_UNF});
        stb(ADDR_STB_FTX);
        tx_byte_ready <= 1'b0;
        chk({5'h00, radio_status.state}, {5'h00, ST_CODE_IDLE});
        $display("test tx fifo done");
        stb(ADDR_STB_RX);
        for (int i = 0; i < 23; i++)
        begin
            seed = nxt(seed);
            if (i < 20)
                exp_so.push_back(seed[7:0]);
            rx_in(seed[7:0]);
        end
        rx_byte_valid <= 1'b0;
        chk({4'h0, radio_status.avail}, {4'h0, AVAIL_MAX});
        stb(ADDR_STB_IDLE);
        m.sel();
        m.xfer(HDR_RX_SINGLE, 0);
        m.xfer(8'h00, 1);
        m.xfer(HDR_RX_BURST, 0);
        repeat (19) m.xfer(8'h00, 1);
        m.desel();
        chk({4'h0, radio_status.avail}, 8'h03);
        $display("test rx fifo done");
        m.sel();
        m.xfer({2'b01, ADDR_PA_TABLE}, 0);
        for (int i = 0; i < 8; i++)
        begin
            seed = nxt(seed);
            pa[i] = seed[7:0];
            m.xfer(pa[i], 0);
        end
        m.desel();
        m.sel();
        m.xfer({2'b11, ADDR_PA_TABLE}, 0);
        for (int i = 0; i < 9; i++)
        begin
            exp_so.push_back(pa[i % 8]);
            m.xfer(8'h00, 1);
        end
        m.desel();
        for (int i = 0; i < 8; i++)
        begin
            pa_power_index <= 3'(i);
            m.wt(3);
            chk(pa_power_setting, pa[i]);
        end
        stb(ADDR_STB_PWD);
        chk({4'h0, radio_status.avail}, 8'h00);
        m.sel();
        m.xfer({2'b11, ADDR_PA_TABLE}, 0);
        for (int i = 0; i < 8; i++)
        begin
            exp_so.push_back(i == 0 ? pa[0] : 8'h00);
            m.xfer(8'h00, 1);
        end
        m.desel();
        $display("test table and sleep done");
        pin_control_enable <= 1'b1;
        m.pin(2'b11);
        chk({5'h00, radio_status.state}, {5'h00, ST_CODE_RX});
        m.wiggle();
        chk({5'h00, radio_status.state}, {5'h00, ST_CODE_RX});
        m.pin(2'b01);
        chk({5'h00, radio_status.state}, {5'h00, ST_CODE_TX});
        seed = nxt(seed);
        serial_mode_en <= 1'b1;
        general_output_a_i <= seed[0];
        general_output_a_value <= seed[1];
        m.wt(5);
        chk({7'h00, general_output_a_oe_n}, 8'h01);
        chk({7'h00, serial_tx_bit}, {7'h00, seed[0]});
        general_output_a_i <= ~seed[0];
        m.wt(5);
        chk({7'h00, serial_tx_bit}, {7'h00, ~seed[0]});
        chk({7'h00, general_output_a_o}, {7'h00, seed[1]});
        serial_mode_en <= 1'b0;
        m.pin(2'b10);
        chk({5'h00, radio_status.state}, {5'h00, ST_CODE_IDLE});
        pin_control_enable <= 1'b0;
        $display("test pin control done");
        status_pin_general_en <= 1'b1;
        status_pin_general_value <= seed[2];
        m.wt(2);
        chk({7'h00, general_output_a_oe_n}, 8'h00);
        chk({7'h00, shared_status_output_oe_n}, 8'h00);
        chk({7'h00, shared_status_output_o}, {7'h00, seed[2]});
        // exponent 15 over 2^13 cycles gives exactly 256 plus mantissa ticks
        seed = nxt(seed);
        rate_mantissa <= seed[7:0];
        rate_exponent <= 4'hF;
        m.wt(4);
        tick_on <= 1'b1;
        m.wt(8192);
        tick_on <= 1'b0;
        m.wt(2);
        chk(8'(ticks), rate_mantissa);
        chk(8'(ticks >> 8), 8'h01);
        $display("test rate done");
        m.wt(5);
        chk(8'(exp_so.size()), 8'h00);
        print_verdict();
    end
endmodule : tb_rfp_radio_port
